// file: rtl/cls_pkg.sv
// package for the compact load/store execute unit: operations, bases, widths, constants
// assumes a 64-bit register file and a byte-addressed data path on the far side
package cls_pkg;

   localparam int XLEN = 64;

   // operation codes seen by the unit
   typedef enum logic [3:0] {
      CLS_OP_NONE = 4'h0,
      LOAD_BYTE_SIGNED = 4'h1,
      LOAD_BYTE_ZERO_EXT = 4'h2,
      LOAD_HALF_SIGNED = 4'h3,
      LOAD_HALF_ZERO_EXT = 4'h4,
      LOAD_WORD_OP = 4'h5,
      LOAD_WORD_ZERO_EXT = 4'h6,
      LOAD_DOUBLE_OP = 4'h7,
      STORE_BYTE_OP = 4'h8,
      STORE_HALF_OP = 4'h9,
      STORE_WORD_OP = 4'hA,
      STORE_DOUBLE_OP = 4'hB
   } cls_op_t;

   // base register choice
   typedef enum logic [1:0] {
      CLS_BASE_GPR = 2'h0,
      CLS_BASE_SP = 2'h1,
      CLS_BASE_PC = 2'h2
   } cls_base_t;

   // pc-relative origin choice
   typedef enum logic [1:0] {
      CLS_ORIG_OWN = 2'h0,
      CLS_ORIG_PREFIX = 2'h1,
      CLS_ORIG_JUMP = 2'h2
   } cls_orig_t;

   // one issued compact memory instruction
   typedef struct packed {
      cls_op_t            op;
      cls_base_t          base;
      cls_orig_t          orig;
      logic               longImm;   // 8-bit field form
      logic               extended;  // prefix present
      logic [15:0]        imm;       // raw field, or 16-bit prefix offset
      logic [XLEN-1:0]    gprBase;
      logic [XLEN-1:0]    spBase;
      logic [XLEN-1:0]    ownPc;
      logic [XLEN-1:0]    prefixPc;
      logic [XLEN-1:0]    jumpPc;
      logic [XLEN-1:0]    storeData; // target_reg_field or return_address_reg value
      logic [4:0]         destIdx;
   } cls_req_t;

   // processor mode
   typedef struct packed {
      logic mode64;
      logic kernel;
   } cls_mode_t;

   // access to the memory path
   typedef struct packed {
      logic               valid;
      logic               write;
      logic [XLEN-1:0]    addr;
      logic [1:0]         size;      // log2 of bytes
      logic [XLEN-1:0]    wdata;
   } cls_mem_t;

   // result to the register file
   typedef struct packed {
      logic               valid;
      logic [4:0]         idx;
      logic [XLEN-1:0]    data;
   } cls_wb_t;

   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   localparam logic [1:0] SZ_DBL  = 2'h3;
   localparam int SHORT_IMM_W = 5;
   localparam int LONG_IMM_W  = 8;
   localparam logic [2:0] ALIGN_HALF = 3'h1;
   localparam logic [2:0] ALIGN_WORD = 3'h3;
   localparam logic [2:0] ALIGN_DBL  = 3'h7;

endpackage : cls_pkg

// file: rtl/cls_load_store_unit.sv
// compact instruction load/store execute stage: address, checks, extension, write-back
// assumes a memory path answering loads with memRdValid some cycles after the request
`timescale 1ns/1ps

// Function
// - address is always a base register, or the origin pc with low bits masked, plus an immediate offset, nothing else
// - signed byte load uses zero-extended 5-bit offset, sign-extends the byte
// - unsigned byte load uses same addressing, zero-extends the byte
// - halfword loads scale 5-bit offset by two; signed or zero extension
// - halfword access with odd address raises address error
// - word load scales 5-bit offset by four; sign-extends word in 64-bit mode
// - word access with either low address bit set raises address error
// - pc-relative word load masks two low pc bits, adds 8-bit offset times four
// - sp-relative word load/store, return address too, adds 8-bit offset times four
// - unsigned word load scales offset by four, zero-extends the loaded word
// - unsigned word and doubleword ops need 64-bit or kernel mode, else reserved
// - doubleword loads scale 5-bit offset by eight and load 64 bits
// - doubleword access with any of three low address bits set raises address error
// - pc-relative doubleword load masks three low pc bits, adds 5-bit offset times eight
// - byte store adds 5-bit offset, writes only the low byte
// - halfword store scales offset by two, writes the low halfword
// - word store scales offset by four, writes the low word
// - doubleword store scales 5-bit offset by eight, writes all 64 bits
// - sp doubleword store of return address scales 8-bit offset by eight
// - pc origin is own pc, prefix pc when extended, jump pc in a delay slot
// - with the extend prefix the offset is a 16-bit signed value
module cls_load_store_unit
   import cls_pkg::*;
(
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // issue side
   input  wire logic               reqValid,
   input  wire cls_req_t           req,
   input  wire cls_mode_t          mode,
   output      logic               reqReady,
   // memory path
   output      cls_mem_t           mem,
   input  wire logic               memReady,
   input  wire logic               memRdValid,
   input  wire logic [XLEN-1:0]    memRdData,
   // results
   output      cls_wb_t            wb,
   output      logic               addrErr,
   output      logic               resvInstr,
   output      logic [XLEN-1:0]    badAddr
);

   typedef enum logic [2:0] {
      CLS_IDLE = 3'b001,
      CLS_REQ  = 3'b010,
      CLS_WAIT = 3'b100
   } cls_state_t;

   cls_state_t         state_reg, state_next;
   cls_mem_t           mem_reg;
   cls_op_t            op_reg;
   logic               mode64_reg;
   logic [4:0]         dest_reg;
   logic [2:0]         lane_reg;

   // operation classes
   wire logic isLoad   = (req.op >= LOAD_BYTE_SIGNED) && (req.op <= LOAD_DOUBLE_OP);
   wire logic isStore  = (req.op >= STORE_BYTE_OP) && (req.op <= STORE_DOUBLE_OP);
   wire logic isMemOp  = isLoad || isStore;
   wire logic [1:0] accSize =
      (req.op == LOAD_BYTE_SIGNED || req.op == LOAD_BYTE_ZERO_EXT ||
       req.op == STORE_BYTE_OP) ? SZ_BYTE :
      (req.op == LOAD_HALF_SIGNED || req.op == LOAD_HALF_ZERO_EXT ||
       req.op == STORE_HALF_OP) ? SZ_HALF :
      (req.op == LOAD_DOUBLE_OP || req.op == STORE_DOUBLE_OP) ? SZ_DBL : SZ_WORD;
   wire logic wideOnly = (req.op == LOAD_WORD_ZERO_EXT) || (accSize == SZ_DBL);

   // pc origin selection
   wire logic [XLEN-1:0] originPc =
      req.extended ? req.prefixPc :
      (req.orig == CLS_ORIG_JUMP) ? req.jumpPc : req.ownPc;

   // masked pc: two low bits for words, three for doublewords
   wire logic [XLEN-1:0] maskMask =
      (accSize == SZ_DBL) ? ~XLEN'(ALIGN_DBL) : ~XLEN'(ALIGN_WORD);
   wire logic [XLEN-1:0] baseVal =
      (req.base == CLS_BASE_PC) ? (originPc & maskMask) :
      (req.base == CLS_BASE_SP) ? req.spBase : req.gprBase;

   // zero-extended field, 5 or 8 bits wide, then scaled by access size
   wire logic [LONG_IMM_W-1:0] fieldImm =
      req.longImm ? req.imm[LONG_IMM_W-1:0]
                  : LONG_IMM_W'(req.imm[SHORT_IMM_W-1:0]);
   wire logic [XLEN-1:0] shortOff = XLEN'(fieldImm) << accSize;
   wire logic [XLEN-1:0] extOff   = {{(XLEN-16){req.imm[15]}}, req.imm};
   wire logic [XLEN-1:0] effAddr  =
      baseVal + (req.extended ? extOff : shortOff);

   // alignment and mode checks
   wire logic [2:0] alignMask =
      (accSize == SZ_HALF) ? ALIGN_HALF :
      (accSize == SZ_WORD) ? ALIGN_WORD :
      (accSize == SZ_DBL)  ? ALIGN_DBL : 3'h0;
   wire logic misaligned = |(effAddr[2:0] & alignMask);
   wire logic modeBad    = wideOnly && !mode.mode64 && !mode.kernel;
   wire logic issue      = reqValid && reqReady && isMemOp;
   wire logic fault      = modeBad || misaligned;

   // store data lane placement: only the low slice of the source
   wire logic [XLEN-1:0] storeSlice =
      (accSize == SZ_BYTE) ? XLEN'(req.storeData[7:0]) :
      (accSize == SZ_HALF) ? XLEN'(req.storeData[15:0]) :
      (accSize == SZ_WORD) ? XLEN'(req.storeData[31:0]) :
                             req.storeData;
   wire logic [XLEN-1:0] storeLane = storeSlice << {effAddr[2:0], 3'h0};

   assign reqReady = (state_reg == CLS_IDLE);

   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CLS_IDLE: begin
            if (issue && !fault) begin
               state_next = CLS_REQ;
            end
         end
         CLS_REQ: begin
            if (memReady) begin
               state_next = mem_reg.write ? CLS_IDLE : CLS_WAIT;
            end
         end
         CLS_WAIT: begin
            if (memRdValid) begin
               state_next = CLS_IDLE;
            end
         end
         default: state_next = CLS_IDLE;
      endcase
   end

   // load lane extraction from the returned doubleword
   wire logic [XLEN-1:0] rdShift = memRdData >> {lane_reg, 3'h0};
   logic [XLEN-1:0] loadVal;
   always_comb begin
      case (op_reg)
         LOAD_BYTE_SIGNED:   loadVal = {{(XLEN-8){rdShift[7]}}, rdShift[7:0]};
         LOAD_BYTE_ZERO_EXT: loadVal = XLEN'(rdShift[7:0]);
         LOAD_HALF_SIGNED:   loadVal = {{(XLEN-16){rdShift[15]}}, rdShift[15:0]};
         LOAD_HALF_ZERO_EXT: loadVal = XLEN'(rdShift[15:0]);
         LOAD_WORD_OP:       loadVal = mode64_reg ?
                                       {{(XLEN-32){rdShift[31]}}, rdShift[31:0]} :
                                       XLEN'(rdShift[31:0]);
         LOAD_WORD_ZERO_EXT: loadVal = XLEN'(rdShift[31:0]);
         LOAD_DOUBLE_OP:     loadVal = rdShift;
         default:            loadVal = '0;
      endcase
   end

   // state and captured access
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg  <= CLS_IDLE;
         mem_reg    <= '0;
         op_reg     <= CLS_OP_NONE;
         mode64_reg <= 1'b0;
         dest_reg   <= 5'h0;
         lane_reg   <= 3'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == CLS_IDLE) begin
            mem_reg.valid <= issue && !fault;
            mem_reg.write <= isStore;
            mem_reg.addr  <= effAddr;
            mem_reg.size  <= accSize;
            mem_reg.wdata <= storeLane;
            op_reg        <= req.op;
            mode64_reg    <= mode.mode64;
            dest_reg      <= req.destIdx;
            lane_reg      <= effAddr[2:0];
         end else if (state_reg == CLS_REQ && memReady) begin
            mem_reg.valid <= 1'b0;
         end
      end
   end

   // exception flags and write-back, one-cycle pulses
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addrErr   <= 1'b0;
         resvInstr <= 1'b0;
         badAddr   <= '0;
         wb        <= '0;
      end else begin
         resvInstr <= issue && modeBad;
         addrErr   <= issue && !modeBad && misaligned;
         if (issue && !modeBad && misaligned) begin
            badAddr <= effAddr;
         end
         wb.valid <= (state_reg == CLS_WAIT) && memRdValid;
         wb.idx   <= dest_reg;
         wb.data  <= loadVal;
      end
   end

   assign mem = mem_reg;

endmodule : cls_load_store_unit

// file: bench/cls_mem_model.sv
// memory path model: accepts a request after a set number of stall cycles
// assumes one request at a time from the load/store unit
`timescale 1ns/1ps
module cls_mem_model
   import cls_pkg::*;
(
   // clock and reset
   input  wire logic            sys_clk,
   input  wire logic            rst,
   // request side
   input  wire cls_mem_t        mem,
   input  wire logic [3:0]      stall,
   output      logic            memReady,
   output      logic            memRdValid,
   output      logic [XLEN-1:0] memRdData = '0
);
   logic [3:0] waitCnt;
   // every doubleword holds a pattern tied to its own address
   wire [XLEN-1:0] rdPat = 64'hF1E2D3C4B5A69788 ^ {mem.addr[XLEN-1:3], 3'h0};
   // idle read data toggles so a stale value never looks valid
   always @(posedge sys_clk) begin
      memRdValid <= 1'b0;
      memRdData <= ~memRdData;
      memReady <= 1'b0;
      if (rst)
         waitCnt <= 4'h0;
      else if (mem.valid && !memReady) begin
         if (waitCnt >= stall) begin
            memReady <= 1'b1;
            waitCnt <= 4'h0;
         end
         else
            waitCnt <= waitCnt + 4'h1;
      end
      if (memReady && mem.valid && !mem.write) begin
         memRdValid <= 1'b1;
         memRdData <= rdPat;
      end
   end
endmodule : cls_mem_model

// file: bench/cls_load_store_unit_properties.sv
// checker for the compact load/store unit: alignment, faults, timing
// assumes it is bound onto cls_load_store_unit
`timescale 1ns/1ps
module cls_load_store_unit_properties
   import cls_pkg::*;
(
   // watched ports
   input wire logic            sys_clk,
   input wire logic            rst,
   input wire logic            reqValid,
   input wire cls_req_t        req,
   input wire cls_mode_t       mode,
   input wire logic            reqReady,
   input wire cls_mem_t        mem,
   input wire logic            memReady,
   input wire logic            memRdValid,
   input wire logic [XLEN-1:0] memRdData,
   input wire cls_wb_t         wb,
   input wire logic            addrErr,
   input wire logic            resvInstr,
   input wire logic [XLEN-1:0] badAddr
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // accepted request and short-form addresses
   wire take = reqValid && reqReady && req.op != CLS_OP_NONE;
   wire gprRaw = take && req.base == CLS_BASE_GPR && !req.extended;
   wire [XLEN-1:0] byteAddr = req.gprBase + {59'h0, req.imm[4:0]};
   wire [XLEN-1:0] halfAddr = req.gprBase + {58'h0, req.imm[4:0], 1'b0};
   wire halfOp = req.op == LOAD_HALF_SIGNED || req.op == STORE_HALF_OP;
   wire wideOp = req.op == LOAD_WORD_ZERO_EXT || req.op == LOAD_DOUBLE_OP
                 || req.op == STORE_DOUBLE_OP;
   AST_HALF_ALIGN: assert property (mem.valid && mem.size == SZ_HALF |-> !mem.addr[0])
      else $error("odd halfword address issued");
   AST_WORD_ALIGN: assert property (mem.valid && mem.size == SZ_WORD |-> mem.addr[1:0] == 2'h0)
      else $error("misaligned word issued");
   AST_DBL_ALIGN: assert property (mem.valid && mem.size == SZ_DBL |-> mem.addr[2:0] == 3'h0)
      else $error("misaligned doubleword issued");
   AST_RESV_MODE: assert property (take && wideOp && !mode.mode64 && !mode.kernel |=> resvInstr)
      else $error("wide op in user mode not refused");
   AST_FAULT_QUIET: assert property (addrErr || resvInstr |-> !mem.valid && !wb.valid)
      else $error("faulting op reached memory or register");
   AST_BYTE_ADDR: assert property (gprRaw && req.op == STORE_BYTE_OP
      |=> mem.valid && mem.addr == $past(byteAddr))
      else $error("byte store address wrong");
   AST_HALF_ERR: assert property (gprRaw && halfOp && halfAddr[0]
      |=> addrErr && badAddr == $past(halfAddr))
      else $error("odd halfword not flagged");
   AST_WB_AFTER_RD: assert property (memRdValid |=> wb.valid)
      else $error("load data not written back");
endmodule : cls_load_store_unit_properties

bind cls_load_store_unit cls_load_store_unit_properties chk (.sys_clk(sys_clk), .rst(rst),
   .reqValid(reqValid), .req(req), .mode(mode), .reqReady(reqReady), .mem(mem),
   .memReady(memReady), .memRdValid(memRdValid), .memRdData(memRdData), .wb(wb),
   .addrErr(addrErr), .resvInstr(resvInstr), .badAddr(badAddr));

// file: bench/compact_isa_load_store_unit_tb_top.sv
// testbench for the compact load/store unit: loads, stores, sp and pc forms, faults
// assumes the memory path model and the bound checker
`timescale 1ns/1ps
module compact_isa_load_store_unit_tb_top;
   import cls_pkg::*;
   localparam logic [63:0] PAT = 64'hF1E2D3C4B5A69788;
   localparam logic [63:0] SRC = 64'h0123456789ABCDEF;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   logic [3:0] stall = 4'h0;
   cls_req_t req = '0;
   cls_mode_t mode = 2'h3;
   logic reqReady, memReady, memRdValid, addrErr, resvInstr, seen;
   logic [XLEN-1:0] memRdData, badAddr, ad, wd, rd, d;
   logic [1:0] flt;
   logic [4:0] wi;
   cls_mem_t mem;
   cls_wb_t wb;
   int errors = 0;
   int checks = 0;
   // clock and parts
   always #25 sys_clk = ~sys_clk;
   cls_load_store_unit dut (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .req(req),
      .mode(mode), .reqReady(reqReady), .mem(mem), .memReady(memReady),
      .memRdValid(memRdValid), .memRdData(memRdData), .wb(wb), .addrErr(addrErr),
      .resvInstr(resvInstr), .badAddr(badAddr));
   cls_mem_model mdl (.sys_clk(sys_clk), .rst(rst), .mem(mem), .stall(stall),
      .memReady(memReady), .memRdValid(memRdValid), .memRdData(memRdData));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // issue one op and collect address, data and faults until idle
   task automatic run(input cls_op_t op, input cls_base_t b, input logic [15:0] imm,
                      input logic lng, input logic ext);
      @(negedge sys_clk);
      req.op = op;
      req.base = b;
      req.imm = imm;
      req.longImm = lng;
      req.extended = ext;
      reqValid = 1'b1;
      {flt, seen, ad, wd, rd, wi} = '0;
      for (int n = 0; n < 40; n++) begin
         @(negedge sys_clk);
         reqValid = 1'b0;
         if (addrErr || resvInstr) flt = {resvInstr, addrErr};
         if (mem.valid) begin
            seen = 1'b1;
            ad = mem.addr;
            wd = mem.wdata;
         end
         if (wb.valid) begin
            rd = wb.data;
            wi = wb.idx;
         end
         if (n > 0 && reqReady && !mem.valid) break;
      end
   endtask : run
   task automatic ld(input cls_op_t op, input logic [4:0] i, input logic [63:0] ea, ev);
      req.destIdx = i;
      run(op, CLS_BASE_GPR, {11'h0, i}, 1'b0, 1'b0);
      chk(ad, ea);
      chk(rd, ev);
      chk(64'(wi), 64'(i));
   endtask : ld
   task automatic st(input cls_op_t op, input logic [4:0] i, input logic [63:0] ea, m, ev);
      run(op, CLS_BASE_GPR, {11'h0, i}, 1'b0, 1'b0);
      chk(ad, ea);
      chk(wd & m, ev);
   endtask : st
   task automatic xa(input cls_op_t op, input cls_base_t b, input logic [15:0] i,
                     input logic lng, ext, input logic [63:0] ea);
      run(op, b, i, lng, ext);
      chk(ad, ea);
   endtask : xa
   task automatic ft(input cls_op_t op, input logic [63:0] g, input logic [1:0] ef);
      req.gprBase = g;
      run(op, CLS_BASE_GPR, 16'h0000, 1'b0, 1'b0);
      chk(64'(flt), 64'(ef));
      chk(64'(seen), 64'(ef == 2'h0));
   endtask : ft
   task automatic t_loads();
      req.gprBase = 64'h1000;
      d = PAT ^ 64'h1000;
      ld(LOAD_BYTE_SIGNED, 5'h03, 64'h1003, {{56{d[31]}}, d[31:24]});
      ld(LOAD_BYTE_ZERO_EXT, 5'h07, 64'h1007, {56'h0, d[63:56]});
      ld(LOAD_HALF_SIGNED, 5'h03, 64'h1006, {{48{d[63]}}, d[63:48]});
      ld(LOAD_HALF_ZERO_EXT, 5'h01, 64'h1002, {48'h0, d[31:16]});
      ld(LOAD_WORD_OP, 5'h01, 64'h1004, {{32{d[63]}}, d[63:32]});
      ld(LOAD_WORD_ZERO_EXT, 5'h01, 64'h1004, {32'h0, d[63:32]});
      ld(LOAD_DOUBLE_OP, 5'h02, 64'h1010, PAT ^ 64'h1010);
   endtask : t_loads
   task automatic t_stores();
      stall = 4'h3;
      req.storeData = SRC;
      st(STORE_BYTE_OP, 5'h05, 64'h1005, 64'hFF << 40, 64'(SRC[7:0]) << 40);
      st(STORE_HALF_OP, 5'h03, 64'h1006, 64'hFFFF << 48, 64'(SRC[15:0]) << 48);
      st(STORE_WORD_OP, 5'h01, 64'h1004, 64'hFFFFFFFF << 32, 64'(SRC[31:0]) << 32);
      st(STORE_DOUBLE_OP, 5'h01, 64'h1008, '1, SRC);
      stall = 4'h0;
   endtask : t_stores
   task automatic t_forms();
      req.ownPc = 64'h2007;
      req.jumpPc = 64'h300F;
      req.prefixPc = 64'h5002;
      req.spBase = 64'h4000;
      xa(LOAD_WORD_OP, CLS_BASE_PC, 16'h0081, 1'b1, 1'b0, 64'h2208);
      req.orig = CLS_ORIG_JUMP;
      xa(LOAD_DOUBLE_OP, CLS_BASE_PC, 16'h001F, 1'b0, 1'b0, 64'h3100);
      xa(LOAD_WORD_OP, CLS_BASE_SP, 16'h00FF, 1'b1, 1'b0, 64'h43FC);
      xa(STORE_WORD_OP, CLS_BASE_SP, 16'h0001, 1'b1, 1'b0, 64'h4004);
      xa(STORE_DOUBLE_OP, CLS_BASE_SP, 16'h0010, 1'b1, 1'b0, 64'h4080);
      chk(wd, SRC);
      xa(LOAD_BYTE_SIGNED, CLS_BASE_GPR, 16'hFFFE, 1'b0, 1'b1, 64'h0FFE);
      xa(LOAD_WORD_OP, CLS_BASE_PC, 16'h0010, 1'b0, 1'b1, 64'h5010);
   endtask : t_forms
   task automatic t_faults();
      ft(LOAD_HALF_SIGNED, 64'h1001, 2'h1);
      chk(badAddr, 64'h1001);
      ft(STORE_HALF_OP, 64'h1001, 2'h1);
      ft(STORE_WORD_OP, 64'h1002, 2'h1);
      ft(LOAD_DOUBLE_OP, 64'h1004, 2'h1);
      mode = 2'h0;
      ft(LOAD_WORD_ZERO_EXT, 64'h1000, 2'h2);
      ft(STORE_DOUBLE_OP, 64'h1000, 2'h2);
      mode = 2'h1;
      ft(LOAD_DOUBLE_OP, 64'h1000, 2'h0);
   endtask : t_faults
   task automatic conclude();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   // watchdog against a hung handshake
   initial begin
      #200000;
      errors++;
      conclude();
   end
   // reset, then the scenarios
   initial begin
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      t_loads();
      t_stores();
      t_forms();
      t_faults();
      conclude();
   end
endmodule : compact_isa_load_store_unit_tb_top
